// *** spcc_pkg.sv ***
package spcc_pkg;
	localparam int SPCC_ADDR_W = 10;
	localparam logic [9:0] SPCC_RESET_ADDR = 10'h000;
	localparam logic [9:0] SPCC_DISC_ADDR = 10'h3FE;
	localparam logic [9:0] SPCC_SYNC_ADDR = 10'h3FF;
	localparam logic [3:0] SPCC_FULL_LEN = 4'hA;
	localparam logic [3:0] SPCC_LEN_SAT = 4'hB;
	localparam logic [1:0] SPCC_PAIR_IDLE = 2'h3;
	localparam logic [1:0] SPCC_PAIR_SEL = 2'h0;
	localparam logic [1:0] SPCC_PAIR_ONE = 2'h1;
	localparam logic [1:0] SPCC_PAIR_ZERO = 2'h2;

	typedef enum logic [3:0] {
		SPCC_TLR, SPCC_RTI, SPCC_SEL_DR, SPCC_CAP_DR, SPCC_SHIFT_DR, SPCC_EXIT1_DR,
		SPCC_PAUSE_DR, SPCC_EXIT2_DR, SPCC_UPD_DR, SPCC_SEL_IR, SPCC_CAP_IR,
		SPCC_SHIFT_IR, SPCC_EXIT1_IR, SPCC_PAUSE_IR, SPCC_EXIT2_IR, SPCC_UPD_IR
	} spcc_tap_t;

	typedef enum logic [1:0] {SPCC_RX_HUNT, SPCC_RX_DATA, SPCC_RX_END} spcc_rx_t;

	typedef enum logic [2:0] {
		SPCC_RES_MATCH, SPCC_RES_NO_MATCH, SPCC_RES_DISCONNECT,
		SPCC_RES_RESET, SPCC_RES_TEST_SYNC, SPCC_RES_HARD_ERR
	} spcc_result_t;

	typedef enum logic [1:0] {SPCC_ST_OFF, SPCC_ST_ON, SPCC_ST_RESET, SPCC_ST_MULTICAST} spcc_status_t;

	typedef struct packed {
		spcc_result_t result;
		spcc_status_t status;
	} spcc_event_t;
endpackage

// *** spcc_connect_control.sv ***
`timescale 1ns/10ps
`default_nettype none
module spcc_connect_control
	import spcc_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_reset,
	input wire logic i_primary_test_clock,
	input wire logic i_primary_test_reset_n,
	input wire logic i_primary_mode_select,
	input wire logic i_primary_serial_in,
	input wire logic [9:0] i_board_address_straps,
	output spcc_status_t o_connect_status,
	output spcc_result_t o_result,
	output logic o_result_pulse,
	output logic o_primary_serial_out_oe,
	output logic o_secondary_serial_out_oe,
	output logic o_secondary_mode_hold,
	output logic o_secondary_mode_force_high
);
	// classify a bit pair: first bit then second bit
	function automatic logic [1:0] spcc_pair(input logic first, input logic second);
		return {first, second};
	endfunction

	function automatic logic spcc_is_pause(input spcc_tap_t s);
		return (s == SPCC_PAUSE_DR) || (s == SPCC_PAUSE_IR);
	endfunction

	// ---------------- link domain ----------------
	logic lpor_meta_q, lpor_q;
	logic [9:0] strap_meta_q, strap_q;
	spcc_tap_t tap_q, tap_d, tap_last_q;
	spcc_rx_t rx_q;
	logic phase_q, first_q, h2_q, h1_q;
	logic [3:0] cnt_q;
	logic [9:0] addr_q;
	logic ones_q, zeros_q;
	spcc_event_t ev_q;
	logic ev_tog_q;
	logic rx_en, tap_moved, pair_done, done, hard;
	logic [1:0] pr;
	spcc_event_t ev_d;

	// power-up reset and straps come from other domains, so both are double-flopped
	always_ff @(posedge i_primary_test_clock) begin
		lpor_meta_q <= i_reset;
		lpor_q <= lpor_meta_q;
		strap_meta_q <= i_board_address_straps;
		strap_q <= strap_meta_q;
	end

	// standard tap next-state walk
	always_comb begin
		unique case (tap_q)
			SPCC_TLR: tap_d = i_primary_mode_select ? SPCC_TLR : SPCC_RTI;
			SPCC_RTI: tap_d = i_primary_mode_select ? SPCC_SEL_DR : SPCC_RTI;
			SPCC_SEL_DR: tap_d = i_primary_mode_select ? SPCC_SEL_IR : SPCC_CAP_DR;
			SPCC_CAP_DR: tap_d = i_primary_mode_select ? SPCC_EXIT1_DR : SPCC_SHIFT_DR;
			SPCC_SHIFT_DR: tap_d = i_primary_mode_select ? SPCC_EXIT1_DR : SPCC_SHIFT_DR;
			SPCC_EXIT1_DR: tap_d = i_primary_mode_select ? SPCC_UPD_DR : SPCC_PAUSE_DR;
			SPCC_PAUSE_DR: tap_d = i_primary_mode_select ? SPCC_EXIT2_DR : SPCC_PAUSE_DR;
			SPCC_EXIT2_DR: tap_d = i_primary_mode_select ? SPCC_UPD_DR : SPCC_SHIFT_DR;
			SPCC_UPD_DR: tap_d = i_primary_mode_select ? SPCC_SEL_DR : SPCC_RTI;
			SPCC_SEL_IR: tap_d = i_primary_mode_select ? SPCC_TLR : SPCC_CAP_IR;
			SPCC_CAP_IR: tap_d = i_primary_mode_select ? SPCC_EXIT1_IR : SPCC_SHIFT_IR;
			SPCC_SHIFT_IR: tap_d = i_primary_mode_select ? SPCC_EXIT1_IR : SPCC_SHIFT_IR;
			SPCC_EXIT1_IR: tap_d = i_primary_mode_select ? SPCC_UPD_IR : SPCC_PAUSE_IR;
			SPCC_PAUSE_IR: tap_d = i_primary_mode_select ? SPCC_EXIT2_IR : SPCC_PAUSE_IR;
			SPCC_EXIT2_IR: tap_d = i_primary_mode_select ? SPCC_UPD_IR : SPCC_SHIFT_IR;
			SPCC_UPD_IR: tap_d = i_primary_mode_select ? SPCC_SEL_DR : SPCC_RTI;
		endcase
	end

	// monitor of the primary port only; the secondary chain may sit elsewhere
	always_ff @(posedge i_primary_test_clock or negedge i_primary_test_reset_n) begin
		if (!i_primary_test_reset_n) begin
			tap_q <= SPCC_TLR;
			tap_last_q <= SPCC_TLR;
		end else if (lpor_q) begin
			tap_q <= SPCC_TLR;
			tap_last_q <= SPCC_TLR;
		end else begin
			tap_q <= tap_d;
			tap_last_q <= tap_q;
		end
	end

	// protocols only in the four stable non-shift states
	assign rx_en = (tap_q == SPCC_TLR) || (tap_q == SPCC_RTI) || spcc_is_pause(tap_q);
	assign tap_moved = tap_q != tap_last_q;
	assign pr = spcc_pair(first_q, i_primary_serial_in);
	assign pair_done = phase_q && rx_en && !tap_moved;
	assign done = (rx_q == SPCC_RX_END) && pair_done && (pr == SPCC_PAIR_IDLE);
	// data seen then a framing slip, a bad trailer or a state change
	assign hard = (cnt_q != 4'h0) && (rx_q != SPCC_RX_HUNT) && ((!rx_en || tap_moved) ||
		(pair_done && (rx_q == SPCC_RX_DATA) && (pr == SPCC_PAIR_IDLE)) ||
		(pair_done && (rx_q == SPCC_RX_END) && (pr != SPCC_PAIR_IDLE)));

	// bit-pair receiver; aligns on a high followed by a select pair
	always_ff @(posedge i_primary_test_clock or negedge i_primary_test_reset_n) begin
		if (!i_primary_test_reset_n) begin
			rx_q <= SPCC_RX_HUNT;
			phase_q <= 1'b0;
			first_q <= 1'b1;
			h2_q <= 1'b1;
			h1_q <= 1'b1;
			cnt_q <= 4'h0;
			addr_q <= 10'h000;
			ones_q <= 1'b1;
			zeros_q <= 1'b1;
		end else if (lpor_q) begin
			rx_q <= SPCC_RX_HUNT;
			phase_q <= 1'b0;
			first_q <= 1'b1;
			h2_q <= 1'b1;
			h1_q <= 1'b1;
			cnt_q <= 4'h0;
			addr_q <= 10'h000;
			ones_q <= 1'b1;
			zeros_q <= 1'b1;
		end else begin
			h2_q <= h1_q;
			h1_q <= i_primary_serial_in;
			phase_q <= !phase_q;
			if (!phase_q)
				first_q <= i_primary_serial_in;
			if (!rx_en || tap_moved || done || hard) begin
				rx_q <= SPCC_RX_HUNT;
			end else begin
				unique case (rx_q)
					SPCC_RX_HUNT: begin
						if (h2_q && !h1_q && !i_primary_serial_in) begin
							rx_q <= SPCC_RX_DATA;
							phase_q <= 1'b0;
							cnt_q <= 4'h0;
							ones_q <= 1'b1;
							zeros_q <= 1'b1;
						end
					end
					SPCC_RX_DATA: begin
						if (phase_q) begin
							if (pr == SPCC_PAIR_ONE || pr == SPCC_PAIR_ZERO) begin
								if (cnt_q < SPCC_FULL_LEN)
									addr_q[cnt_q] <= (pr == SPCC_PAIR_ONE);
								if (cnt_q != SPCC_LEN_SAT)
									cnt_q <= cnt_q + 4'h1;
								ones_q <= ones_q && (pr == SPCC_PAIR_ONE);
								zeros_q <= zeros_q && (pr == SPCC_PAIR_ZERO);
							end else if (pr == SPCC_PAIR_SEL && cnt_q != 4'h0) begin
								rx_q <= SPCC_RX_END;
							end else if (pr == SPCC_PAIR_IDLE) begin
								rx_q <= SPCC_RX_HUNT; // soft error before any data
							end
						end
					end
					SPCC_RX_END: begin
					end
				endcase
			end
		end
	end

	// result of a finished protocol; globals are checked ahead of the straps
	always_comb begin
		ev_d = '{result: SPCC_RES_HARD_ERR, status: SPCC_ST_OFF};
		if (hard) begin
			ev_d = '{result: SPCC_RES_HARD_ERR, status: SPCC_ST_OFF};
		end else if (cnt_q < SPCC_FULL_LEN) begin
			ev_d = '{result: SPCC_RES_HARD_ERR, status: SPCC_ST_OFF};
		end else if (zeros_q) begin
			ev_d = '{result: SPCC_RES_RESET, status: SPCC_ST_RESET};
		end else if (ones_q) begin
			if (spcc_is_pause(tap_q))
				ev_d = '{result: SPCC_RES_TEST_SYNC, status: SPCC_ST_MULTICAST};
			else
				ev_d = '{result: SPCC_RES_DISCONNECT, status: SPCC_ST_OFF};
		end else if (cnt_q != SPCC_FULL_LEN) begin
			ev_d = '{result: SPCC_RES_HARD_ERR, status: SPCC_ST_OFF};
		end else if (addr_q == SPCC_DISC_ADDR) begin
			ev_d = '{result: SPCC_RES_DISCONNECT, status: SPCC_ST_OFF};
		end else if (addr_q == strap_q) begin
			ev_d = '{result: SPCC_RES_MATCH, status: SPCC_ST_ON};
		end else begin
			ev_d = '{result: SPCC_RES_NO_MATCH, status: SPCC_ST_OFF};
		end
	end

	// word held stable and flagged by a toggle for the system clock side
	always_ff @(posedge i_primary_test_clock) begin
		if (lpor_q) begin
			ev_q <= '{result: SPCC_RES_NO_MATCH, status: SPCC_ST_OFF};
			ev_tog_q <= 1'b0;
		end else if (done || hard) begin
			ev_q <= ev_d;
			ev_tog_q <= !ev_tog_q;
		end
	end

	a_short_addr: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && cnt_q < SPCC_FULL_LEN) |=> (ev_q.result == SPCC_RES_HARD_ERR && ev_q.status == SPCC_ST_OFF))
		else $error("short address did not give a hard error");
	a_long_mixed: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && cnt_q == SPCC_LEN_SAT && !ones_q && !zeros_q) |=> ev_q.status == SPCC_ST_OFF)
		else $error("long mixed address did not disconnect");
	a_zero_reset: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && zeros_q && cnt_q >= SPCC_FULL_LEN) |=> ev_q.result == SPCC_RES_RESET)
		else $error("all-zero address did not reset");
	a_sync_paused: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && ones_q && cnt_q >= SPCC_FULL_LEN && !spcc_is_pause(tap_q))
		|=> ev_q.result == SPCC_RES_DISCONNECT)
		else $error("test-sync accepted outside pause");
	// a frame cut by a state change after its first data pair reports a hard error, so only an idle receiver must stay quiet
	a_ignore_busy: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(!rx_en && rx_q == SPCC_RX_HUNT) |=> (rx_q == SPCC_RX_HUNT && $stable(ev_tog_q)))
		else $error("protocol taken in a busy tap state");
	a_tlr_hold: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(tap_q == SPCC_TLR && i_primary_mode_select && i_primary_test_reset_n)[*2] |=> tap_q == SPCC_TLR)
		else $error("monitor left reset with mode-select high");
	a_trst_force: assert property (@(posedge i_primary_test_clock)
		!i_primary_test_reset_n |-> tap_q == SPCC_TLR)
		else $error("monitor not in reset under primary reset");
	a_tap_step: assert property (@(posedge i_primary_test_clock)
		disable iff (lpor_q || !i_primary_test_reset_n)
		(tap_q == SPCC_RTI && i_primary_mode_select) |=> tap_q == SPCC_SEL_DR)
		else $error("monitor did not leave idle on mode-select high");

	// the checks below pin the address map one row at a time
	a_strap_match: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && cnt_q == SPCC_FULL_LEN && !ones_q && !zeros_q &&
		addr_q != SPCC_DISC_ADDR && addr_q == strap_q)
		|=> (ev_q.result == SPCC_RES_MATCH && ev_q.status == SPCC_ST_ON))
		else $error("strapped address did not connect");
	a_other_addr: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && cnt_q == SPCC_FULL_LEN && !ones_q && !zeros_q &&
		addr_q != SPCC_DISC_ADDR && addr_q != strap_q)
		|=> (ev_q.result == SPCC_RES_NO_MATCH && ev_q.status == SPCC_ST_OFF))
		else $error("unknown address did not disconnect");
	a_disc_addr: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && cnt_q == SPCC_FULL_LEN && addr_q == SPCC_DISC_ADDR)
		|=> (ev_q.result == SPCC_RES_DISCONNECT && ev_q.status == SPCC_ST_OFF))
		else $error("disconnect address not obeyed");
	a_sync_multi: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		(done && ones_q && cnt_q >= SPCC_FULL_LEN && spcc_is_pause(tap_q))
		|=> (ev_q.result == SPCC_RES_TEST_SYNC && ev_q.status == SPCC_ST_MULTICAST))
		else $error("test-sync not taken in pause");
	// a broken frame must never leave a connection behind
	a_hard_off: assert property (@(posedge i_primary_test_clock) disable iff (lpor_q)
		hard |=> (ev_q.result == SPCC_RES_HARD_ERR && ev_q.status == SPCC_ST_OFF))
		else $error("hard error did not disconnect");

	// ---------------- system clock domain ----------------
	logic tog_meta_q, tog_sync_q, tog_last_q;
	spcc_status_t status_q;
	spcc_result_t result_q;
	logic pulse_q, pri_oe_q, sec_oe_q, hold_q, force_q;
	logic ev_seen;

	// first stage is read only by the second
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			tog_meta_q <= 1'b0;
			tog_sync_q <= 1'b0;
			tog_last_q <= 1'b0;
		end else begin
			tog_meta_q <= ev_tog_q;
			tog_sync_q <= tog_meta_q;
			tog_last_q <= tog_sync_q;
		end
	end

	assign ev_seen = tog_sync_q != tog_last_q;

	// status moves only on a finished or broken protocol
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			status_q <= SPCC_ST_OFF;
			result_q <= SPCC_RES_NO_MATCH;
			pulse_q <= 1'b0;
		end else begin
			pulse_q <= ev_seen;
			if (ev_seen) begin
				status_q <= ev_q.status;
				result_q <= ev_q.result;
			end
		end
	end

	// pin controls follow the status a cycle later so all outputs leave flops
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			pri_oe_q <= 1'b0;
			sec_oe_q <= 1'b0;
			hold_q <= 1'b1;
			force_q <= 1'b0;
		end else begin
			pri_oe_q <= status_q == SPCC_ST_ON;
			sec_oe_q <= (status_q == SPCC_ST_ON) || (status_q == SPCC_ST_MULTICAST);
			hold_q <= status_q == SPCC_ST_OFF;
			force_q <= status_q == SPCC_ST_RESET;
		end
	end

	assign o_connect_status = status_q;
	assign o_result = result_q;
	assign o_result_pulse = pulse_q;
	assign o_primary_serial_out_oe = pri_oe_q;
	assign o_secondary_serial_out_oe = sec_oe_q;
	assign o_secondary_mode_hold = hold_q;
	assign o_secondary_mode_force_high = force_q;

	a_status_hold: assert property (@(posedge i_mclk) disable iff (i_reset)
		!ev_seen |=> $stable(status_q))
		else $error("status changed without a protocol");
	a_off_release: assert property (@(posedge i_mclk) disable iff (i_reset)
		(status_q == SPCC_ST_OFF)[*2] |-> (!o_primary_serial_out_oe && !o_secondary_serial_out_oe && o_secondary_mode_hold))
		else $error("outputs driven while disconnected");
	a_pulse_result: assert property (@(posedge i_mclk) disable iff (i_reset)
		ev_seen |=> (o_result_pulse && o_connect_status == $past(ev_q.status)))
		else $error("result not taken with its pulse");
	// pin controls lag the status by one cycle, hence two cycles of history
	a_reset_force: assert property (@(posedge i_mclk) disable iff (i_reset)
		(status_q == SPCC_ST_RESET)[*2] |->
		(o_secondary_mode_force_high && !o_primary_serial_out_oe && !o_secondary_serial_out_oe))
		else $error("reset status did not force mode-select high");
	a_on_drive: assert property (@(posedge i_mclk) disable iff (i_reset)
		(status_q == SPCC_ST_ON)[*2] |-> (o_primary_serial_out_oe && o_secondary_serial_out_oe))
		else $error("connected status left outputs released");
endmodule
`default_nettype wire

// *** spcc_master_model.sv ***
`timescale 1ns/10ps
`default_nettype none
// bus master on the multidrop primary port; its link clock runs only while it has work
module spcc_master_model (
	output logic o_tck,
	output logic o_tms,
	output logic o_tdi,
	output logic o_trst_n
);
	// idle levels: serial line sits at its pull-up level, reset released
	initial begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b1;
		o_trst_n = 1'b1;
	end

	// one link cycle: levels change in the low half, the device samples on the rise
	task automatic cyc(input logic m, input logic d);
		o_tms = m;
		o_tdi = d;
		#24 o_tck = 1'b1;
		#24 o_tck = 1'b0;
	endtask

	// mode-select walk through the monitor states, first step in bit 0
	task automatic walk(input logic [7:0] b, input int n);
		for (int i = 0; i < n; i++) begin
			cyc(b[i], 1'b1);
		end
	endtask

	// mode-select held level for the whole protocol so the monitor never moves mid-frame
	task automatic send(input logic [15:0] dat, input int n, input logic m);
		for (int i = 0; i < 4; i++) begin
			cyc(m, 1'b1);
		end
		cyc(m, 1'b0);
		cyc(m, 1'b0);
		for (int i = 0; i < n; i++) begin
			cyc(m, ~dat[i]);
			cyc(m, dat[i]);
		end
		cyc(m, 1'b0);
		cyc(m, 1'b0);
		cyc(m, 1'b1);
		cyc(m, 1'b1);
	endtask

	// reset acts before any link edge; one edge then falls inside it to show the monitor pinned
	task automatic trst();
		o_trst_n = 1'b0;
		#30 cyc(1'b0, 1'b1);
		o_trst_n = 1'b1;
	endtask
endmodule
`default_nettype wire

// *** spcc_connect_control_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module spcc_connect_control_tb;
	import spcc_pkg::*;
	localparam logic [9:0] board_addr = 10'h2A5;
	logic i_mclk;
	logic i_reset;
	wire tck;
	wire tms;
	wire tdi;
	wire trst_n;
	spcc_status_t st;
	spcc_result_t res;
	logic pulse;
	logic [3:0] outs;
	logic [4:0] last_q;
	int num_errors = 0;
	int tests_run = 0;
	int pulses = 0;

	spcc_master_model u_spcc_master_model (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n));

	spcc_connect_control u_spcc_connect_control (.i_mclk(i_mclk), .i_reset(i_reset),
		.i_primary_test_clock(tck), .i_primary_test_reset_n(trst_n), .i_primary_mode_select(tms),
		.i_primary_serial_in(tdi), .i_board_address_straps(board_addr), .o_connect_status(st),
		.o_result(res), .o_result_pulse(pulse), .o_primary_serial_out_oe(outs[3]),
		.o_secondary_serial_out_oe(outs[2]), .o_secondary_mode_hold(outs[1]),
		.o_secondary_mode_force_high(outs[0]));

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// latch what the block reports in the cycle it flags a new result
	always @(posedge i_mclk) begin
		if (pulse === 1'b1) begin
			pulses <= pulses + 1;
			last_q <= {res, st};
		end
	end

	// pin levels that each status must give
	function automatic logic [3:0] outs_of(input spcc_status_t s);
		return {s == SPCC_ST_ON, s == SPCC_ST_ON || s == SPCC_ST_MULTICAST, s == SPCC_ST_OFF, s == SPCC_ST_RESET};
	endfunction

	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// send one protocol and expect exactly one result with the given status
	task automatic proto(input logic [15:0] d, input int n, input logic m, input spcc_result_t r,
		input spcc_status_t s);
		int p0;
		int k;
		p0 = pulses;
		u_spcc_master_model.send(d, n, m);
		k = 0;
		while (pulses == p0 && k < 20) begin
			@(posedge i_mclk);
			k++;
		end
		if (k == 20) begin
			num_errors++;
			$display("[FAIL] t=%0t no result got=%h exp=%h", $time, pulses, p0 + 1);
			close_out();
		end
		repeat (2) @(posedge i_mclk);
		#1;
		chk({3'h0, last_q}, {3'h0, r, s});
		chk({4'h0, outs}, {4'h0, outs_of(s)});
		chk(pulses[7:0], p0[7:0] + 8'h01);
	endtask

	// protocol that must be ignored: no result, status kept
	task automatic ignored(input logic [15:0] d, input spcc_status_t s);
		int p0;
		p0 = pulses;
		u_spcc_master_model.send(d, 10, 1'b0);
		repeat (20) @(posedge i_mclk);
		chk(pulses[7:0], p0[7:0]);
		chk({6'h0, st}, {6'h0, s});
	endtask

	task automatic t_power_up();
		chk({3'h0, st, res}, {3'h0, SPCC_ST_OFF, SPCC_RES_NO_MATCH});
		chk({3'h0, pulse, outs}, {3'h0, 1'h0, 4'h2});
		proto(16'h03FF, 10, 1'b1, SPCC_RES_DISCONNECT, SPCC_ST_OFF);
		u_spcc_master_model.walk(8'h00, 1);
		$display("test power_up done");
	endtask

	task automatic t_addr_map();
		proto({6'h0, board_addr}, 10, 1'b0, SPCC_RES_MATCH, SPCC_ST_ON);
		proto(16'h02A4, 10, 1'b0, SPCC_RES_NO_MATCH, SPCC_ST_OFF);
		proto({6'h0, board_addr}, 10, 1'b0, SPCC_RES_MATCH, SPCC_ST_ON);
		proto(16'h0000, 10, 1'b0, SPCC_RES_RESET, SPCC_ST_RESET);
		proto(16'h03FE, 10, 1'b0, SPCC_RES_DISCONNECT, SPCC_ST_OFF);
		proto(16'h03FF, 10, 1'b0, SPCC_RES_DISCONNECT, SPCC_ST_OFF);
		$display("test addr_map done");
	endtask

	task automatic t_pause();
		u_spcc_master_model.walk(8'h05, 4);
		proto(16'h03FF, 10, 1'b0, SPCC_RES_TEST_SYNC, SPCC_ST_MULTICAST);
		proto(16'hFFFF, 12, 1'b0, SPCC_RES_TEST_SYNC, SPCC_ST_MULTICAST);
		u_spcc_master_model.walk(8'h2F, 7);
		proto(16'h03FE, 10, 1'b0, SPCC_RES_DISCONNECT, SPCC_ST_OFF);
		proto(16'h03FF, 10, 1'b0, SPCC_RES_TEST_SYNC, SPCC_ST_MULTICAST);
		u_spcc_master_model.walk(8'h03, 3);
		$display("test pause done");
	endtask

	task automatic t_length();
		proto({6'h0, board_addr}, 10, 1'b0, SPCC_RES_MATCH, SPCC_ST_ON);
		proto({6'h0, board_addr}, 9, 1'b0, SPCC_RES_HARD_ERR, SPCC_ST_OFF);
		proto(16'h0000, 11, 1'b0, SPCC_RES_RESET, SPCC_ST_RESET);
		proto(16'h06A5, 11, 1'b0, SPCC_RES_HARD_ERR, SPCC_ST_OFF);
		$display("test length done");
	endtask

	// shift state must drop the frame; the status set before stays put
	task automatic t_refused();
		proto({6'h0, board_addr}, 10, 1'b0, SPCC_RES_MATCH, SPCC_ST_ON);
		u_spcc_master_model.walk(8'h01, 3);
		ignored(16'h03FE, SPCC_ST_ON);
		u_spcc_master_model.walk(8'h03, 3);
		$display("test refused done");
	endtask

	// monitor left in pause; the stopped-clock reset, not a mode-select-high walk, brings it to test-logic-reset
	task automatic t_async_reset();
		u_spcc_master_model.walk(8'h05, 4);
		u_spcc_master_model.trst();
		proto(16'h03FF, 10, 1'b1, SPCC_RES_DISCONNECT, SPCC_ST_OFF);
		proto({6'h0, board_addr}, 10, 1'b1, SPCC_RES_MATCH, SPCC_ST_ON);
		$display("test async_reset done");
	endtask

	initial begin
		i_reset = 1'b1;
		fork
			repeat (20) @(posedge i_mclk);
			u_spcc_master_model.walk(8'hFF, 4);
		join
		@(posedge i_mclk);
		#1 i_reset = 1'b0;
		u_spcc_master_model.walk(8'hFF, 3);
		t_power_up();
		t_addr_map();
		t_pause();
		t_length();
		t_refused();
		t_async_reset();
		close_out();
	end
endmodule
`default_nettype wire
